/* rtl/lock_pkg.sv */
// Shared constants for the serial lock and soft reset command logic.
package lock_pkg;

    // ************************************************************
    // Instruction codes.
    // ************************************************************
    localparam logic [7:0] OP_READ_LOCK   = 8'h3d;
    localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
    localparam logic [7:0] OP_GLOBAL_FREE = 8'h98;
    localparam logic [7:0] OP_LOCK_ONE    = 8'h36;
    localparam logic [7:0] OP_UNLOCK_ONE  = 8'h39;
    localparam logic [7:0] OP_RESET_ARM   = 8'h66;
    localparam logic [7:0] OP_RESET_GO    = 8'h99;
    localparam logic [7:0] OP_WRITE_EN    = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS   = 8'h04;

    // ************************************************************
    // Field layout and reset values.
    // ************************************************************
    localparam int ADDR_BITS   = 24;
    localparam int REGION_LSB  = 16;
    localparam int REGION_BITS = 8;
    localparam int NUM_REGIONS = 256;
    localparam logic LOCK_RESET = 1'b1;
    localparam int LOCK_LSB    = 0;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_MHZ          = 200;
    localparam int RESET_TIME_US    = 30;
    localparam int RESET_CYCLES     = RESET_TIME_US * CLK_MHZ;
    localparam int SELECT_DELAY_US  = 20;
    localparam int SELECT_CYCLES    = SELECT_DELAY_US * CLK_MHZ;
    localparam int WRITE_DELAY_MS   = 5;
    localparam int WRITE_CYCLES     = WRITE_DELAY_MS * 1000 * CLK_MHZ;
    localparam int SCK_HALF         = 2;

    // ************************************************************
    // Host command codes.
    // ************************************************************
    localparam logic [2:0] CMD_QUERY   = 3'h0;
    localparam logic [2:0] CMD_GLOCK   = 3'h1;
    localparam logic [2:0] CMD_GFREE   = 3'h2;
    localparam logic [2:0] CMD_LOCK    = 3'h3;
    localparam logic [2:0] CMD_UNLOCK  = 3'h4;
    localparam logic [2:0] CMD_WREN    = 3'h5;
    localparam logic [2:0] CMD_ARM     = 3'h6;
    localparam logic [2:0] CMD_RESET   = 3'h7;

endpackage

/* rtl/lock_link_if.sv */
// Serial link between the flash command logic and its host.
interface lock_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport flash (input cs_n, input sck, input mosi,
                   output miso, output miso_oe);
    modport host  (output cs_n, output sck, output mosi,
                   input miso, input miso_oe);
endinterface

/* rtl/lock_flash_end.sv */
// Flash side command logic: region lock bits and soft reset.
// Operation
// - Lock bits protect only when scheme select set.
// - Lock bits volatile, all set after reset.
// - Query is 3Dh plus 24-bit address.
// - Status byte out on falling edges, MSB first.
// - Status LSB one means region locked.
// - Bare 7Eh sets every lock bit.
// - Bare 98h clears every lock bit.
// - Global commands need write enable latch.
// - Reset needs 66h then 99h frames.
// - Any other command disarms pending reset.
// - Reset clears volatile status and settings.
// - Refuse all commands for reset time.
// - Host checks busy and suspend first; lock_host_end reads neither flag.
// - Host waits after power before commands.
// - 36h plus address locks one region.
// - 39h plus address unlocks one region.
//
// Decided for this implementation: the plain strobed port and the address map.
module lock_flash_end #(
    parameter int RESET_CYCLES = lock_pkg::RESET_CYCLES
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    lock_link_if.flash                link,
    input  wire logic                 protect_scheme_select_i,
    input  wire logic                 protect_complement_i,
    input  wire logic                 sector_granularity_select_i,
    input  wire logic                 top_bottom_select_i,
    input  wire logic [2:0]           protect_range_field_i,
    input  wire logic [7:0]           check_region_i,
    output logic                      region_protected_o,
    output logic                      write_enable_latch_o,
    output logic                      suspend_flag_o,
    output logic                      reset_busy_o
);

    typedef struct packed {
        logic [lock_pkg::NUM_REGIONS-1:0] locks;
        logic        sck_prev;
        logic        cs_prev;
        logic [5:0]  bit_cnt;
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [7:0]  tx;
        logic        tx_on;
        logic        write_enable_latch;
        logic        armed;
        logic        susp;
        logic [7:0]  read_param;
        logic [2:0]  wrap;
        logic [15:0] rst_cnt;
        logic        prot;
    } state_t;

    state_t q, d;

    logic       sck_rise;
    logic       sck_fall;
    logic       frame_end;
    logic [7:0] shifted_op;
    logic [7:0] region;
    logic       range_hit;

    assign sck_rise  = link.sck & ~q.sck_prev;
    assign sck_fall  = ~link.sck & q.sck_prev;
    assign frame_end = link.cs_n & ~q.cs_prev;
    assign region    = q.addr[lock_pkg::REGION_LSB +: lock_pkg::REGION_BITS];

    // ************************************************************
    // Fallback range protection from the status bits.
    // ************************************************************
    // Simplified range model: each step of the range field covers an
    // eighth of the array from the top or bottom; sector select halves it.
    always_comb begin
        logic [3:0] span;
        logic [7:0] pos;
        span = {1'b0, protect_range_field_i} << 1;
        if (sector_granularity_select_i) begin
            span = {1'b0, protect_range_field_i};
        end
        pos = top_bottom_select_i ? check_region_i : ~check_region_i;
        range_hit = ({4'h0, pos[7:4]} < {4'h0, span});
        if (protect_complement_i) begin
            range_hit = ~range_hit;
        end
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        d = q;
        d.sck_prev = link.sck;
        d.cs_prev  = link.cs_n;
        shifted_op = {q.opcode[6:0], link.mosi};
        d.prot = protect_scheme_select_i ? q.locks[check_region_i]
                                         : range_hit;
        if (q.rst_cnt != 16'h0000) begin
            // Commands arriving now are dropped entirely.
            d.rst_cnt = q.rst_cnt - 16'h0001;
            d.bit_cnt = 6'h00;
            d.tx_on   = 1'b0;
        end else if (link.cs_n) begin
            d.bit_cnt = 6'h00;
            d.tx_on   = 1'b0;
            if (frame_end && q.bit_cnt >= 6'd8) begin
                // Commands act only when the frame closes after at least eight bits.
                if (q.opcode != lock_pkg::OP_RESET_GO) begin
                    d.armed = 1'b0;
                end
                case (q.opcode)
                    lock_pkg::OP_WRITE_EN: begin
                        d.write_enable_latch = 1'b1;
                    end
                    lock_pkg::OP_WRITE_DIS: begin
                        d.write_enable_latch = 1'b0;
                    end
                    lock_pkg::OP_GLOBAL_LOCK: begin
                        if (q.write_enable_latch && q.bit_cnt == 6'd8) begin
                            d.locks = '1;
                            d.write_enable_latch   = 1'b0;
                        end
                    end
                    lock_pkg::OP_GLOBAL_FREE: begin
                        if (q.write_enable_latch && q.bit_cnt == 6'd8) begin
                            d.locks = '0;
                            d.write_enable_latch   = 1'b0;
                        end
                    end
                    lock_pkg::OP_LOCK_ONE: begin
                        if (q.write_enable_latch && q.bit_cnt == 6'd32) begin
                            d.locks[region] = 1'b1;
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    lock_pkg::OP_UNLOCK_ONE: begin
                        if (q.write_enable_latch && q.bit_cnt == 6'd32) begin
                            d.locks[region] = 1'b0;
                            d.write_enable_latch = 1'b0;
                        end
                    end
                    lock_pkg::OP_RESET_ARM: begin
                        d.armed = (q.bit_cnt == 6'd8);
                    end
                    lock_pkg::OP_RESET_GO: begin
                        if (q.armed && q.bit_cnt == 6'd8) begin
                            d.armed      = 1'b0;
                            d.locks      = '1;
                            d.write_enable_latch        = 1'b0;
                            d.susp       = 1'b0;
                            d.read_param = 8'h00;
                            d.wrap       = 3'h0;
                            d.rst_cnt    = 16'(RESET_CYCLES);
                        end else begin
                            d.armed = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (sck_rise) begin
            // Input bits are taken on rising serial clock edges.
            if (q.bit_cnt < 6'd8) begin
                d.opcode = shifted_op;
            end else if (q.bit_cnt < 6'd32) begin
                d.addr = {q.addr[22:0], link.mosi};
            end
            if (q.bit_cnt != 6'h3f) begin
                d.bit_cnt = q.bit_cnt + 6'h01;
            end
        end else if (sck_fall && q.opcode == lock_pkg::OP_READ_LOCK
                     && q.bit_cnt >= 6'd32) begin
            // Status byte leaves MSB first, changing on falling edges.
            if (q.tx_on) begin
                d.tx = {q.tx[6:0], q.tx[7]};
            end else begin
                d.tx = 8'h00;
                d.tx[lock_pkg::LOCK_LSB] = q.locks[region];
                d.tx_on = 1'b1;
            end
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q       <= '0;
            q.locks <= '1;
            q.sck_prev <= 1'b0;
            q.cs_prev  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.miso            = q.tx[7];
    assign link.miso_oe         = q.tx_on & ~link.cs_n;
    assign region_protected_o   = q.prot;
    assign write_enable_latch_o = q.write_enable_latch;
    assign suspend_flag_o       = q.susp;
    assign reset_busy_o         = (q.rst_cnt != 16'h0000);

endmodule

/* rtl/lock_host_end.sv */
// Host side controller that frames lock and reset commands.
module lock_host_end #(
    parameter int SELECT_CYCLES = lock_pkg::SELECT_CYCLES,
    parameter int WRITE_CYCLES  = lock_pkg::WRITE_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    lock_link_if.host        link,
    input  wire logic [1:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o
);

    typedef enum logic [1:0] {IDLE, SHIFT, GAP} phase_t;

    typedef struct packed {
        phase_t      phase;
        logic [31:0] sh;
        logic [5:0]  nbits;
        logic [5:0]  cnt;
        logic [1:0]  half;
        logic        sck;
        logic        cs_n;
        logic [7:0]  rx;
        logic [2:0]  cmd;
        logic        done;
        logic [20:0] pwr;
        logic [31:0] rdata;
    } state_t;

    state_t q, d;

    // ************************************************************
    // Command register, status register and serial engine.
    // ************************************************************
    // Writes at word 0 start a command: bits 2:0 command, 31:8 address.
    // Writes are refused until the power-up delay ends; any command but a
    // query is refused until the longer write delay ends.
    always_comb begin
        logic ready;
        logic [7:0] op;
        op = 8'h00;
        d = q;
        ready = (q.pwr >= 21'(SELECT_CYCLES));
        if (q.pwr < 21'(WRITE_CYCLES)) begin
            d.pwr = q.pwr + 21'h1;
        end
        case (wdata_i[2:0])
            lock_pkg::CMD_QUERY:  op = lock_pkg::OP_READ_LOCK;
            lock_pkg::CMD_GLOCK:  op = lock_pkg::OP_GLOBAL_LOCK;
            lock_pkg::CMD_GFREE:  op = lock_pkg::OP_GLOBAL_FREE;
            lock_pkg::CMD_LOCK:   op = lock_pkg::OP_LOCK_ONE;
            lock_pkg::CMD_UNLOCK: op = lock_pkg::OP_UNLOCK_ONE;
            lock_pkg::CMD_WREN:   op = lock_pkg::OP_WRITE_EN;
            lock_pkg::CMD_ARM:    op = lock_pkg::OP_RESET_ARM;
            default:              op = lock_pkg::OP_RESET_GO;
        endcase
        d.rdata = 32'h0;
        if (rd_i) begin
            d.rdata = (addr_i == 2'h1)
                ? {28'h0, q.pwr >= 21'(WRITE_CYCLES), ready,
                   q.phase == IDLE, q.done}
                : {24'h0, q.rx};
        end
        case (q.phase)
            IDLE: begin
                d.cs_n = 1'b1;
                d.sck  = 1'b0;
                if (wr_i && addr_i == 2'h0 && ready &&
                    (wdata_i[2:0] == lock_pkg::CMD_QUERY ||
                     q.pwr >= 21'(WRITE_CYCLES))) begin
                    d.cmd   = wdata_i[2:0];
                    d.sh    = {op, wdata_i[31:8]};
                    d.nbits = (wdata_i[2:0] <= lock_pkg::CMD_UNLOCK &&
                               wdata_i[2:0] != lock_pkg::CMD_GLOCK &&
                               wdata_i[2:0] != lock_pkg::CMD_GFREE)
                              ? 6'd32 : 6'd8;
                    if (wdata_i[2:0] == lock_pkg::CMD_QUERY) begin
                        d.nbits = 6'd40;
                    end
                    d.cnt   = 6'h00;
                    d.half  = 2'h0;
                    d.done  = 1'b0;
                    d.cs_n  = 1'b0;
                    d.phase = SHIFT;
                end
            end
            SHIFT: begin
                d.half = q.half + 2'h1;
                if (q.half == 2'(lock_pkg::SCK_HALF - 1)) begin
                    d.half = 2'h0;
                    d.sck  = ~q.sck;
                    if (!q.sck) begin
                        // Rising edge: response bits are steady here.
                        if (q.cnt >= 6'd32) begin
                            d.rx = {q.rx[6:0], link.miso};
                        end
                    end else begin
                        d.sh  = {q.sh[30:0], 1'b0};
                        d.cnt = q.cnt + 6'h01;
                        if (q.cnt + 6'h01 == q.nbits) begin
                            d.phase = GAP;
                        end
                    end
                end
            end
            GAP: begin
                d.cs_n  = 1'b1;
                d.done  = 1'b1;
                d.phase = IDLE;
            end
            default: begin
                d.phase = IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q       <= '0;
            q.cs_n  <= 1'b1;
            q.phase <= IDLE;
        end else begin
            q <= d;
        end
    end

    assign link.cs_n = q.cs_n;
    assign link.sck  = q.sck;
    assign link.mosi = q.sh[31];
    assign rdata_o   = q.rdata;

endmodule

/* verif/lock_link_checker.sv */
// Concurrent checks on the serial link and the flash end status levels.
module lock_link_checker #(
    parameter int RESET_CYCLES = lock_pkg::RESET_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic reset_busy_o,
    input wire logic write_enable_latch_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Helper counters.
    // ****************************************************************
    logic        sck_q;
    logic [7:0]  rise_q;
    logic [15:0] busy_q;

    // Counts clock rises per frame and cycles spent in the reset wait.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_q  <= 1'b0;
            rise_q <= 8'h00;
            busy_q <= 16'h0000;
        end else begin
            sck_q  <= sck;
            rise_q <= cs_n ? 8'h00 : rise_q + 8'(sck && !sck_q);
            busy_q <= reset_busy_o ? busy_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    sequence s_frame_end;
        $rose(cs_n);
    endsequence
    sequence s_busy_end;
        $fell(reset_busy_o);
    endsequence

    a_oe_in_frame: assert property (miso_oe |-> !cs_n)
        else $error("serial output driven while deselected");
    a_sck_low_idle: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("serial clock runs outside a frame");
    a_sck_low_select: assert property ($fell(cs_n) |-> !sck)
        else $error("frame opened with serial clock high");
    a_whole_bytes: assert property (s_frame_end |->
        rise_q != 8'h00 && rise_q[2:0] == 3'h0)
        else $error("frame closed off a byte boundary");
    a_busy_min: assert property (s_busy_end |->
        busy_q >= 16'(RESET_CYCLES - 1))
        else $error("reset wait ended too early");
    a_busy_bounded: assert property ($rose(reset_busy_o) |->
        ##[1:1000] !reset_busy_o)
        else $error("reset wait never ended");
    a_busy_clears_wel: assert property (reset_busy_o |->
        !write_enable_latch_o)
        else $error("write enable latch kept through reset");
    a_wel_at_deselect: assert property ($changed(write_enable_latch_o)
        |-> cs_n)
        else $error("write enable latch moved inside a frame");
    a_busy_after_frame: assert property ($rose(reset_busy_o) |-> cs_n)
        else $error("reset began inside a frame");
    // Both data lines may only move while the serial clock is low.
    a_mosi_steady: assert property ($changed(mosi) |-> !sck)
        else $error("serial input moved while clock high");
    a_miso_steady: assert property ($changed(miso) |-> !sck)
        else $error("serial output moved while clock high");
endmodule

/* verif/test_sector_lock_and_soft_reset.sv */
// Bench joining host end and flash end across the serial link.
module test_sector_lock_and_soft_reset;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [1:0]  addr    = 2'h0;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        note    = 1'b0;
    logic        pend    = 1'b0;
    logic        scheme  = 1'b1;
    logic        compl   = 1'b0;
    logic        sec     = 1'b0;
    logic        tbs     = 1'b0;
    logic [2:0]  range   = 3'h0;
    logic [7:0]  region  = 8'h00;
    logic [7:0]  rr;
    logic [31:0] rdata;
    logic        prot;
    logic        write_enable_latch;
    logic        busy;
    logic        susp;
    logic        lk[256];
    logic        exp_q[$];
    int          fails   = 0;
    int          checks  = 0;
    int          seed;

    // Free running 200 MHz system clock.
    always #2.5 sys_clk = ~sys_clk;

    lock_link_if link();

    lock_flash_end #(.RESET_CYCLES(50)) i_lock_flash_end (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link.flash),
        .protect_scheme_select_i(scheme), .protect_complement_i(compl),
        .sector_granularity_select_i(sec), .top_bottom_select_i(tbs),
        .protect_range_field_i(range), .check_region_i(region),
        .region_protected_o(prot), .write_enable_latch_o(write_enable_latch),
        .suspend_flag_o(susp), .reset_busy_o(busy));

    lock_host_end #(.SELECT_CYCLES(10), .WRITE_CYCLES(40)) i_lock_host_end (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link.host),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata));

    lock_link_checker #(.RESET_CYCLES(50)) i_lock_link_checker (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .cs_n(link.cs_n),
        .sck(link.sck), .mosi(link.mosi), .miso(link.miso),
        .miso_oe(link.miso_oe), .reset_busy_o(busy),
        .write_enable_latch_o(write_enable_latch));

    // ****************************************************************
    // Comparison, reporting and bus tasks.
    // ****************************************************************
    task chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Query results stand in the cycle after the read strobe, so the note
    // is delayed by one edge and matched mid-cycle, away from the edge.
    always @(posedge sys_clk) begin
        pend <= note;
    end

    // The whole status byte is compared: only its lowest bit may be set.
    always @(negedge sys_clk) begin
        if (pend && exp_q.size() > 0) begin
            chk("query status", rdata, {31'h0, exp_q.pop_front()});
        end
    end

    task rdx(input logic [1:0] a, input logic n, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        note <= n;
        @(posedge sys_clk);
        rd   <= 1'b0;
        note <= 1'b0;
        #1 v = rdata;
    endtask

    // Polls host status until all bits of the mask are set; a hang fails.
    task wait_stat(input logic [3:0] m);
        logic [31:0] v;
        for (int i = 0; i < 4000; i++) begin
            rdx(2'h1, 1'b0, v);
            if ((v[3:0] & m) === m) return;
        end
        fails++;
        stop_test;
    endtask

    // Low address bits are random: any address in a region picks one bit.
    task cmd(input logic [2:0] c, input logic [7:0] r);
        wait_stat(4'he);
        @(posedge sys_clk);
        addr  <= 2'h0;
        wdata <= {r, 8'($urandom), 8'($urandom), 5'h00, c};
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
        wait_stat(4'h3);
    endtask

    task wcmd(input logic [2:0] c, input logic [7:0] r);
        cmd(lock_pkg::CMD_WREN, 8'h00);
        cmd(c, r);
    endtask

    task qry(input logic [7:0] r);
        logic [31:0] v;
        cmd(lock_pkg::CMD_QUERY, r);
        exp_q.push_back(lk[r]);
        rdx(2'h0, 1'b1, v);
        @(posedge sys_clk);
        region <= r;
        scheme <= 1'b1;
        compl  <= 1'($urandom);
        range  <= 3'($urandom);
        repeat (2) @(posedge sys_clk);
        #1 chk("protected", {31'h0, prot}, {31'h0, lk[r]});
        // An empty range leaves only the complement to decide protection.
        @(posedge sys_clk);
        scheme <= 1'b0;
        range  <= 3'h0;
        sec    <= 1'($urandom);
        tbs    <= 1'($urandom);
        repeat (2) @(posedge sys_clk);
        #1 chk("range protected", {31'h0, prot}, {31'h0, compl});
    endtask

    task setall(input logic b);
        foreach (lk[i]) lk[i] = b;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        seed = $urandom(4);
        setall(1'b1);
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) qry(8'($urandom));
        rr = 8'($urandom);
        cmd(lock_pkg::CMD_GFREE, 8'h00);
        qry(rr);
        wcmd(lock_pkg::CMD_GFREE, 8'h00);
        setall(1'b0);
        qry(rr + 8'h01);
        wcmd(lock_pkg::CMD_LOCK, rr);
        lk[rr] = 1'b1;
        qry(rr);
        qry(rr + 8'h01);
        wcmd(lock_pkg::CMD_UNLOCK, rr);
        lk[rr] = 1'b0;
        qry(rr);
        wcmd(lock_pkg::CMD_GLOCK, 8'h00);
        setall(1'b1);
        qry(rr);
        wcmd(lock_pkg::CMD_GFREE, 8'h00);
        setall(1'b0);
        // A query between arm and go must disarm the reset.
        cmd(lock_pkg::CMD_ARM, 8'h00);
        qry(rr);
        cmd(lock_pkg::CMD_RESET, 8'h00);
        chk("reset busy", {31'h0, busy}, 32'h0);
        qry(rr);
        cmd(lock_pkg::CMD_WREN, 8'h00);
        chk("write latch", {31'h0, write_enable_latch}, 32'h1);
        chk("suspend", {31'h0, susp}, 32'h0);
        cmd(lock_pkg::CMD_ARM, 8'h00);
        cmd(lock_pkg::CMD_RESET, 8'h00);
        setall(1'b1);
        for (int i = 0; i < 40 && busy !== 1'b1; i++) @(posedge sys_clk);
        chk("reset busy", {31'h0, busy}, 32'h1);
        chk("write latch", {31'h0, write_enable_latch}, 32'h0);
        chk("suspend", {31'h0, susp}, 32'h0);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk);
        chk("reset busy", {31'h0, busy}, 32'h0);
        qry(rr);
        // A hardware reset in mid-run must lock every region again.
        wcmd(lock_pkg::CMD_GFREE, 8'h00);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        setall(1'b1);
        qry(rr);
        stop_test;
    end
endmodule
